// file: etr_pkg.sv
// constants, register map and state layout for the trigger input router
// assumes a single 50 MHz clock and a byte-addressed avalon-mm slave port
package etr_pkg;

    // lines and channels
    localparam int unsigned NLINE = 5;
    localparam int unsigned NCH   = 4;

    // register groups, selected by address bits 7:5
    localparam logic [2:0] GRP_SRC  = 3'h0; // 0x00 + 4*line
    localparam logic [2:0] GRP_TYPE = 3'h1; // 0x20 + 4*line
    localparam logic [2:0] GRP_RESP = 3'h2; // 0x40 + 4*line
    localparam logic [2:0] GRP_SENS = 3'h3; // 0x60 + 4*line
    localparam logic [7:0] STAT_ADDR = 8'h80;
    localparam logic [7:0] CLR_ADDR  = 8'h84;
    localparam logic [7:0] IEN_ADDR  = 8'h88;
    localparam logic [7:0] CHON_ADDR = 8'h8C;
    localparam logic [7:0] MODE_ADDR = 8'h90;

    // field positions
    localparam int unsigned RESP_CFG_BIT = 7;
    localparam int unsigned STAT_W       = 6;
    localparam int unsigned STAT_REJ_BIT = 5;

    // trigger types
    localparam logic [2:0] TT_RISE = 3'h0;
    localparam logic [2:0] TT_FALL = 3'h1;
    localparam logic [2:0] TT_HIGH = 3'h2;
    localparam logic [2:0] TT_LOW  = 3'h3;
    localparam logic [2:0] TT_BOTH = 3'h4;

    // response actions
    localparam logic [3:0] RA_OFF    = 4'h0;
    localparam logic [3:0] RA_ON     = 4'h1;
    localparam logic [3:0] RA_TOGGLE = 4'h2;
    localparam logic [3:0] RA_POWER  = 4'h3;
    localparam logic [3:0] RA_CV     = 4'h4;
    localparam logic [3:0] RA_CC     = 4'h5;
    localparam logic [3:0] RA_CR     = 4'h6;
    localparam logic [3:0] RA_IND    = 4'h7;
    localparam logic [3:0] RA_SER    = 4'h8;
    localparam logic [3:0] RA_PAR    = 4'h9;

    // channel modes and tracking modes
    localparam logic [1:0] CM_POWER = 2'h0;
    localparam logic [1:0] CM_CV    = 2'h1;
    localparam logic [1:0] CM_CC    = 2'h2;
    localparam logic [1:0] CM_CR    = 2'h3;
    localparam logic [1:0] TM_IND   = 2'h0;
    localparam logic [1:0] TM_SER   = 2'h1;
    localparam logic [1:0] TM_PAR   = 2'h2;

    // whole state of the router
    typedef struct packed {
        logic                 wreq;
        logic                 ack;
        logic [31:0]          rdata;
        logic [4:0]           sync1;
        logic [4:0]           sync2;
        logic [4:0]           prev;
        logic [4:0][3:0]      src;
        logic [4:0][2:0]      ttype;
        logic [4:0][3:0]      resp;
        logic [4:0]           rcfg;
        logic [4:0][1:0]      sens;
        logic [STAT_W-1:0]    stat;
        logic [STAT_W-1:0]    ien;
        logic [3:0]           chon;
        logic [3:0][1:0]      chmode;
        logic [1:0]           track;
        logic                 irq;
    } etr_state_t;

    // after reset: rise, off, low sensitivity, power, independent
    localparam etr_state_t ST_RST = '{wreq: 1'b1, default: '0};

endpackage

// file: etr_router.sv
// external trigger input router: five trigger lines acting on four channels
// assumes lines come from outside the clock domain and are synchronised here;
// software drives the registers over avalon-mm with waitrequest
`timescale 1ns/10ps
`default_nettype none

module etr_router
(
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // trigger lines
    input  wire logic        i_trig_line_0,
    input  wire logic        i_trig_line_1,
    input  wire logic        i_trig_line_2,
    input  wire logic        i_trig_line_3,
    input  wire logic        i_trig_line_4,
    // avalon-mm slave
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [3:0]  i_avs_byteenable,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // channel control and interrupt
    output logic      [3:0]  o_out_channel_on,
    output logic      [7:0]  o_out_channel_mode,
    output logic      [1:0]  o_track_mode,
    output logic             o_irq
);

    etr_pkg::etr_state_t st_r;
    etr_pkg::etr_state_t st_nxt;
    logic [4:0]          trig_in;
    logic [4:0]          trig;
    logic [31:0]         rd_val;
    logic                wr;
    logic [2:0]          grp;
    logic [2:0]          idx;

    assign trig_in = {i_trig_line_4, i_trig_line_3, i_trig_line_2,
                      i_trig_line_1, i_trig_line_0};
    assign grp = i_avs_address[7:5];
    assign idx = i_avs_address[4:2];
    // a write lands only in the cycle the slave drops waitrequest
    assign wr  = st_r.ack & i_avs_write & i_avs_byteenable[0];

    // per-line trigger detector on the synchronised sample
    genvar g;
    generate
        for (g = 0; g < 5; g++)
        begin : g_det
            always_comb
            begin
                case (st_r.ttype[g])
                    etr_pkg::TT_RISE: trig[g] = st_r.sync2[g] & ~st_r.prev[g];
                    etr_pkg::TT_FALL: trig[g] = ~st_r.sync2[g] & st_r.prev[g];
                    etr_pkg::TT_HIGH: trig[g] = st_r.sync2[g];
                    etr_pkg::TT_LOW:  trig[g] = ~st_r.sync2[g];
                    etr_pkg::TT_BOTH: trig[g] = st_r.sync2[g] ^ st_r.prev[g];
                    default:          trig[g] = 1'b0;
                endcase
            end
        end
    endgenerate

    // read mux; unmapped or misaligned addresses read as zero
    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (i_avs_address[1:0] == 2'h0)
        begin
            for (int l = 0; l < 5; l++)
            begin
                if (idx == 3'(l))
                begin
                    case (grp)
                        etr_pkg::GRP_SRC:  rd_val[3:0] = st_r.src[l];
                        etr_pkg::GRP_TYPE: rd_val[2:0] = st_r.ttype[l];
                        etr_pkg::GRP_RESP:
                        begin
                            rd_val[3:0] = st_r.resp[l];
                            rd_val[etr_pkg::RESP_CFG_BIT] = st_r.rcfg[l];
                        end
                        etr_pkg::GRP_SENS: rd_val[1:0] = st_r.sens[l];
                        default:           rd_val = 32'h0000_0000;
                    endcase
                end
            end
            case (i_avs_address)
                etr_pkg::STAT_ADDR: rd_val[5:0] = st_r.stat;
                etr_pkg::IEN_ADDR:  rd_val[5:0] = st_r.ien;
                etr_pkg::CHON_ADDR: rd_val[3:0] = st_r.chon;
                etr_pkg::MODE_ADDR:
                begin
                    rd_val[7:0] = st_r.chmode;
                    rd_val[9:8] = st_r.track;
                end
                default: ;
            endcase
        end
    end

    // next-state logic: synchroniser, bus, actions, status
    always_comb
    begin
        logic [5:0] clr;
        logic       rej;
        logic       pair_ok;
        st_nxt  = st_r;
        clr     = 6'h00;
        rej     = 1'b0;
        pair_ok = 1'b0;

        st_nxt.sync1 = trig_in;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.prev  = st_r.sync2;

        // one wait state per request, then waitrequest drops for a cycle
        st_nxt.ack   = (i_avs_read | i_avs_write) & ~st_r.ack;
        st_nxt.wreq  = ~st_nxt.ack;
        st_nxt.rdata = st_nxt.ack ? rd_val : st_r.rdata;

        // register writes, only the low byte lane carries fields
        if (wr && i_avs_address[1:0] == 2'h0)
        begin
            for (int l = 0; l < 5; l++)
            begin
                if (idx == 3'(l))
                begin
                    case (grp)
                        etr_pkg::GRP_SRC:
                            st_nxt.src[l] = i_avs_writedata[3:0];
                        etr_pkg::GRP_TYPE:
                        begin
                            st_nxt.ttype[l] = i_avs_writedata[2:0];
                            if (i_avs_writedata[2:0] == etr_pkg::TT_BOTH)
                            begin
                                st_nxt.resp[l] = etr_pkg::RA_OFF;
                                st_nxt.rcfg[l] = 1'b1;
                            end
                        end
                        etr_pkg::GRP_RESP:
                        begin
                            st_nxt.resp[l] = i_avs_writedata[3:0];
                            st_nxt.rcfg[l] = 1'b1;
                        end
                        etr_pkg::GRP_SENS:
                            if (st_r.rcfg[l])
                                st_nxt.sens[l] = i_avs_writedata[1:0];
                            else
                                rej = 1'b1;
                        default: ;
                    endcase
                end
            end
            case (i_avs_address)
                etr_pkg::CLR_ADDR:  clr = i_avs_writedata[5:0];
                etr_pkg::IEN_ADDR:  st_nxt.ien = i_avs_writedata[5:0];
                etr_pkg::CHON_ADDR: st_nxt.chon = i_avs_writedata[3:0];
                default: ;
            endcase
        end

        // actions: lines applied in index order, so toggles accumulate
        // and a higher line wins a conflicting on/off in the same cycle
        for (int l = 0; l < 5; l++)
        begin
            if (trig[l])
            begin
                pair_ok = st_r.src[l][0] & st_r.src[l][1] &
                          (st_nxt.chmode[0] == etr_pkg::CM_POWER) &
                          (st_nxt.chmode[1] == etr_pkg::CM_POWER);
                for (int c = 0; c < 4; c++)
                begin
                    if (st_r.src[l][c])
                    begin
                        case (st_r.resp[l])
                            etr_pkg::RA_OFF:   st_nxt.chon[c] = 1'b0;
                            etr_pkg::RA_ON:    st_nxt.chon[c] = 1'b1;
                            etr_pkg::RA_TOGGLE:
                                st_nxt.chon[c] = ~st_nxt.chon[c];
                            etr_pkg::RA_POWER:
                                st_nxt.chmode[c] = etr_pkg::CM_POWER;
                            etr_pkg::RA_CV: st_nxt.chmode[c] = etr_pkg::CM_CV;
                            etr_pkg::RA_CC: st_nxt.chmode[c] = etr_pkg::CM_CC;
                            etr_pkg::RA_CR: st_nxt.chmode[c] = etr_pkg::CM_CR;
                            default: ;
                        endcase
                    end
                end
                // tracking needs channels 1 and 2 both assigned, in power
                if (pair_ok)
                begin
                    case (st_r.resp[l])
                        etr_pkg::RA_IND: st_nxt.track = etr_pkg::TM_IND;
                        etr_pkg::RA_SER: st_nxt.track = etr_pkg::TM_SER;
                        etr_pkg::RA_PAR: st_nxt.track = etr_pkg::TM_PAR;
                        default: ;
                    endcase
                end
            end
        end

        // sticky status: a new event wins over a clear in the same cycle
        st_nxt.stat = (st_r.stat & ~clr) | {rej, trig};
        st_nxt.irq  = |(st_nxt.stat & st_nxt.ien);
    end

    // state register
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            st_r <= etr_pkg::ST_RST;
        else
            st_r <= st_nxt;
    end

    // outputs straight from the state register
    assign o_avs_readdata     = st_r.rdata;
    assign o_avs_waitrequest  = st_r.wreq;
    assign o_out_channel_on   = st_r.chon;
    assign o_out_channel_mode = st_r.chmode;
    assign o_track_mode       = st_r.track;
    assign o_irq              = st_r.irq;

    // checks on the router behaviour
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    logic wr_ln0;
    logic lone0;
    assign wr_ln0 = wr && idx == 3'h0 && i_avs_address[1:0] == 2'h0;
    // line 0 triggering with no other line acting on a channel and no
    // software write to the outputs; idle lines with no channels are ignored
    assign lone0  = trig[0] &&
                    (trig[4:1] & {|st_r.src[4], |st_r.src[3],
                                  |st_r.src[2], |st_r.src[1]}) == 4'h0 &&
                    !(wr && i_avs_address == etr_pkg::CHON_ADDR);

    a_src_store: assert property (
        wr_ln0 && grp == etr_pkg::GRP_SRC
        |=> st_r.src[0] == $past(i_avs_writedata[3:0]))
        else $error("channel enable write not stored");

    a_multi_chan: assert property (
        lone0 && st_r.resp[0] == etr_pkg::RA_ON && st_r.src[0] == 4'hF
        |=> o_out_channel_on == 4'hF)
        else $error("trigger missed an enabled channel");

    a_src_read: assert property (
        !st_r.ack && i_avs_read && i_avs_address == 8'h00
        |=> !o_avs_waitrequest && o_avs_readdata[3:0] == $past(st_r.src[0]))
        else $error("channel list readback wrong");

    a_type_hold: assert property (
        !(wr_ln0 && grp == etr_pkg::GRP_TYPE) |=> $stable(st_r.ttype[0]))
        else $error("trigger type changed without a write");

    a_both_edge: assert property (
        st_r.ttype[4] == etr_pkg::TT_BOTH &&
        !$past(i_rst, 1) && !$past(i_rst, 2) && !$past(i_rst, 3)
        |-> trig[4] == ($past(trig_in[4], 2) != $past(trig_in[4], 3)))
        else $error("both-edge detection wrong");

    a_both_off: assert property (
        wr_ln0 && grp == etr_pkg::GRP_TYPE &&
        i_avs_writedata[2:0] == etr_pkg::TT_BOTH
        |=> st_r.resp[0] == etr_pkg::RA_OFF && st_r.rcfg[0])
        else $error("both-edge type did not force output off");

    a_type_read: assert property (
        !st_r.ack && i_avs_read && i_avs_address == 8'h24
        |=> o_avs_readdata[2:0] == $past(st_r.ttype[1]))
        else $error("trigger type readback wrong");

    a_resp_off: assert property (
        lone0 && st_r.resp[0] == etr_pkg::RA_OFF && st_r.src[0][2]
        |=> !o_out_channel_on[2])
        else $error("off response not applied");

    a_toggle_inv: assert property (
        lone0 && st_r.resp[0] == etr_pkg::RA_TOGGLE && st_r.src[0][1]
        |=> o_out_channel_on[1] != $past(o_out_channel_on[1]))
        else $error("toggle did not invert the output");

    a_sens_rej: assert property (
        wr_ln0 && grp == etr_pkg::GRP_SENS && !st_r.rcfg[0]
        |=> $stable(st_r.sens[0]) && st_r.stat[etr_pkg::STAT_REJ_BIT])
        else $error("sensitivity accepted without a response");

    a_sync_lag: assert property (
        !$past(i_rst, 1) && !$past(i_rst, 2)
        |-> st_r.sync2 == $past(trig_in, 2))
        else $error("synchroniser delay wrong");

    // interrupt tracks enabled status
    a_irq_level: assert property (
        o_irq == |(st_r.stat & st_r.ien))
        else $error("interrupt level does not match status");

    // every request answered in two cycles
    a_bus_answer: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest
        |-> ##[1:2] !o_avs_waitrequest)
        else $error("bus request not answered");

    // main scenarios
    c_toggle: cover property (
        trig[0] && st_r.resp[0] == etr_pkg::RA_TOGGLE && st_r.src[0] != 4'h0);
    c_both_set: cover property (
        wr && grp == etr_pkg::GRP_TYPE &&
        i_avs_writedata[2:0] == etr_pkg::TT_BOTH);
    c_sens_rej: cover property (
        wr && grp == etr_pkg::GRP_SENS && !st_r.rcfg[idx]);
    c_irq_rise: cover property ($rose(o_irq));

endmodule

`default_nettype wire

// file: etr_trig_src.sv
// model of the external contact equipment driving the five trigger lines
// assumes the bench calls set_line from its own sequence, one line per call
`timescale 1ns/10ps
`default_nettype none

module etr_trig_src
(
    // clock
    input  wire logic       i_clk_sys,
    // trigger lines toward the router
    output logic      [4:0] o_lines
);

    // lines rest low; contacts are open at power-up
    initial o_lines = 5'h00;

    // levels change just after a rising edge, held until the next call
    task automatic set_line(input int n, input logic v);
        @(posedge i_clk_sys);
        o_lines[n] <= v;
    endtask

endmodule

`default_nettype wire

// file: test_etr_router.sv
// self-checking bench for the trigger input router
// assumes one 50 MHz clock, avalon-mm register access, lines from etr_trig_src
`timescale 1ns/10ps
`default_nettype none

module test_etr_router;

    logic        i_clk_sys = 1'b0;
    logic        i_rst = 1'b1;
    logic [4:0]  lines;
    logic [7:0]  i_avs_address = 8'h00;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [3:0]  i_avs_byteenable = 4'hF;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [31:0] o_avs_readdata;
    logic        o_avs_waitrequest;
    logic [3:0]  o_out_channel_on;
    logic [7:0]  o_out_channel_mode;
    logic [1:0]  o_track_mode;
    logic        o_irq;
    logic [31:0] rdata;
    int          num_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    // per-line tables: channel enables and responses (line 4 left to both-edges)
    localparam logic [4:0][3:0] SRC_T = {4'h8, 4'h4, 4'h1, 4'h3, 4'hF};
    localparam logic [4:0][3:0] RESP_T = {4'h0, etr_pkg::RA_OFF,
        etr_pkg::RA_CC, etr_pkg::RA_OFF, etr_pkg::RA_ON};

    // clock, 20 ns period
    initial
    begin
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    etr_trig_src i_etr_trig_src (.i_clk_sys(i_clk_sys), .o_lines(lines));

    etr_router i_etr_router (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_trig_line_0(lines[0]), .i_trig_line_1(lines[1]),
        .i_trig_line_2(lines[2]), .i_trig_line_3(lines[3]),
        .i_trig_line_4(lines[4]),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_byteenable(i_avs_byteenable),
        .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest),
        .o_out_channel_on(o_out_channel_on),
        .o_out_channel_mode(o_out_channel_mode),
        .o_track_mode(o_track_mode), .o_irq(o_irq));

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one bus cycle: request held until waitrequest is seen low at an edge
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [31:0] d);
        @(posedge i_clk_sys);
        i_avs_address <= a;
        i_avs_write <= w;
        i_avs_read <= ~w;
        i_avs_writedata <= d;
        do @(posedge i_clk_sys); while (o_avs_waitrequest !== 1'b0);
        rdata = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        access(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask

    // let a line change pass the synchroniser and act
    task automatic settle();
        repeat (6) @(posedge i_clk_sys);
    endtask

    // hang guard: the sequence needs well under 3000 cycles
    always @(posedge i_clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (5) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        // reset contents, unmapped and misaligned places read zero
        rd(8'h00, 32'h0); // reset enables
        rd(8'h20, 32'h0); // reset type
        rd(etr_pkg::STAT_ADDR, 32'h0);
        rd(8'h94, 32'h0);
        rd(8'h02, 32'h0);
        // sensitivity before any response is refused and flagged
        wr(8'h60, 32'h1);
        rd(8'h60, 32'h0); // write ignored
        rd(etr_pkg::STAT_ADDR, 32'h20); // reject flag
        wr(etr_pkg::CLR_ADDR, 32'h20);
        // types and responses first, enables last so no line acts early
        for (int n = 0; n < 5; n++)
        begin
            wr({3'h1, n[2:0], 2'b00}, {29'h0, n[2:0]});
            if (n < 4)
                wr({3'h2, n[2:0], 2'b00}, {28'h0, RESP_T[n]});
            wr({3'h0, n[2:0], 2'b00}, {28'h0, SRC_T[n]});
        end
        for (int n = 0; n < 5; n++)
        begin
            rd({3'h0, n[2:0], 2'b00}, {28'h0, SRC_T[n]}); // enables
            rd({3'h1, n[2:0], 2'b00}, {29'h0, n[2:0]}); // type
        end
        rd(8'h50, 32'h80); // both-edges forces off
        wr(8'h70, 32'h2);
        rd(8'h70, 32'h2); // accepted once configured
        // line 3 is low with type low, so it keeps its status bit set
        wr(etr_pkg::CLR_ADDR, 32'h3F);
        rd(etr_pkg::STAT_ADDR, 32'h08); // low level acts
        wr(etr_pkg::IEN_ADDR, 32'h01);
        chk({31'h0, o_irq}, 32'h0); // masked status keeps irq low
        // line 0 rise turns all on; line 3 low-off wins on channel 3
        i_etr_trig_src.set_line(0, 1'b1);
        settle();
        chk({28'h0, o_out_channel_on}, 32'hB); // all enabled act
        chk({31'h0, o_irq}, 32'h1);
        rd(etr_pkg::STAT_ADDR, 32'h09); // line 0 flagged
        // line 1 falls only: the rise does nothing
        i_etr_trig_src.set_line(1, 1'b1);
        settle();
        chk({28'h0, o_out_channel_on}, 32'hB); // no action on rise
        i_etr_trig_src.set_line(1, 1'b0);
        settle();
        chk({28'h0, o_out_channel_on}, 32'h8); // fall turns off
        // line 4 both edges with forced off response
        i_etr_trig_src.set_line(4, 1'b1);
        settle();
        chk({28'h0, o_out_channel_on}, 32'h0); // output off
        // line 2 high level switches channel 1 to CC
        i_etr_trig_src.set_line(2, 1'b1);
        settle();
        rd(etr_pkg::MODE_ADDR, 32'h2); // mode response
        chk({24'h0, o_out_channel_mode}, 32'h2); // mode pins
        i_etr_trig_src.set_line(2, 1'b0);
        // toggle on line 0, channel 3 freed from line 3
        wr(8'h0C, 32'h0);
        wr(8'h40, {28'h0, etr_pkg::RA_TOGGLE});
        wr(etr_pkg::CHON_ADDR, 32'h5);
        i_etr_trig_src.set_line(0, 1'b0);
        settle();
        chk({28'h0, o_out_channel_on}, 32'h5); // fall ignored
        i_etr_trig_src.set_line(0, 1'b1);
        settle();
        chk({28'h0, o_out_channel_on}, 32'hA); // each bit inverted
        i_etr_trig_src.set_line(0, 1'b0);
        i_etr_trig_src.set_line(0, 1'b1);
        settle();
        chk({28'h0, o_out_channel_on}, 32'h5); // one per edge
        // series tracking on line 1 needs ch1 and ch2 both in power mode
        wr(8'h44, {28'h0, etr_pkg::RA_SER});
        i_etr_trig_src.set_line(1, 1'b1);
        i_etr_trig_src.set_line(1, 1'b0);
        settle();
        chk({30'h0, o_track_mode}, {30'h0, etr_pkg::TM_IND});
        wr(8'h48, {28'h0, etr_pkg::RA_POWER});
        i_etr_trig_src.set_line(2, 1'b1);
        settle();
        chk({24'h0, o_out_channel_mode}, 32'h0); // back to power
        i_etr_trig_src.set_line(1, 1'b1);
        i_etr_trig_src.set_line(1, 1'b0);
        settle();
        chk({30'h0, o_track_mode}, {30'h0, etr_pkg::TM_SER});
        // write with byte 0 disabled is dropped, then clear drops irq
        i_avs_byteenable <= 4'h0;
        wr(etr_pkg::IEN_ADDR, 32'h3F);
        i_avs_byteenable <= 4'hF;
        rd(etr_pkg::IEN_ADDR, 32'h1);
        wr(etr_pkg::CLR_ADDR, 32'h3F);
        repeat (2) @(posedge i_clk_sys);
        chk({31'h0, o_irq}, 32'h0);
        wrap_up();
    end

endmodule

`default_nettype wire
